// File: core/lpp_device.sv
// Device end of the packet ports: receive and transmit packet buffers.
//
// Function
// - Ports exist only with link layer and buffers
// - User clocks read side fast enough
// - Four port clocks, each port on its own
// - Read enable gives data next cycle
// - Without buffer, space indication comes from user
// - Available when fill above threshold or EOP held
// - Valid only with a valid word
// - Start and end of packet marked
// - Error may appear before end of packet
// - Empty-byte count, log2 data width wide
// - Receive width is 8 x size x lanes
// - Packet ID meaningful only with start
// - User write enable marks valid word
// - Transmit space high while buffer not full
// - User marks first transmit word with start
// - Broadcast copies receive ports per function
// - User drives transmit markers, ID and data
`timescale 1ns/1ns
`default_nettype none
`include "lpp_map.svh"

// ---------------------------------------------------------------
// Packet buffer, one per port, single clock.
// ---------------------------------------------------------------
module lpp_pkt_fifo #(
	parameter int DW    = 16,
	parameter int MW    = 4,
	parameter int DEPTH = `LPP_FIFO_DEPTH,
	parameter int THR   = `LPP_FILL_THR
)(
	// Clock, reset, enable
	input  wire logic              clk_i,
	input  wire logic              rst_b_i,
	input  wire logic              ce_i,
	// Fill side
	input  wire logic              wr_i,
	input  wire logic              sop_i,
	input  wire logic              eop_i,
	input  wire logic              err_i,
	input  wire logic [MW-1:0]     mty_i,
	input  wire logic [DW-1:0]     dat_i,
	input  wire lpp_pkg::lpp_adr_t adr_i,
	output logic                   full_o,
	output logic                   dav_o,
	// Drain side
	input  wire logic              rd_i,
	output logic                   val_o,
	output logic                   sop_o,
	output logic                   eop_o,
	output logic                   err_o,
	output logic [MW-1:0]          mty_o,
	output logic [DW-1:0]          dat_o,
	output lpp_pkg::lpp_adr_t      adr_o
);
	import lpp_pkg::*;

	localparam int AW = $clog2(DEPTH);
	localparam int WW = 3 + MW + DW + `LPP_ADR_W;

	logic [WW-1:0] mem_q [DEPTH];
	logic [WW-1:0] head;
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0]   cnt_q;
	logic [AW:0]   eops_q;
	logic          push;
	logic          pop;

	assign head   = mem_q[rp_q];
	// Writes into a full buffer are dropped, so the count never wraps.
	assign full_o = (cnt_q == (AW+1)'(DEPTH));
	assign push   = wr_i && !full_o;
	assign pop    = rd_i && (cnt_q != '0);
	// A short packet must not sit below the threshold forever.
	assign dav_o  = (cnt_q > (AW+1)'(THR)) || (eops_q != '0);

	always_ff @(posedge clk_i)
	begin
		if (ce_i && push)
		begin
			mem_q[wp_q] <= {sop_i, eop_i, err_i, mty_i, dat_i, adr_i};
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			wp_q <= '0;
			rp_q <= '0;
		end
		else if (ce_i)
		begin
			if (push)
			begin
				wp_q <= wp_q + 1'b1;
			end
			if (pop)
			begin
				rp_q <= rp_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			cnt_q  <= '0;
			eops_q <= '0;
		end
		else if (ce_i)
		begin
			case ({push, pop})
				2'b10: cnt_q <= cnt_q + 1'b1;
				2'b01: cnt_q <= cnt_q - 1'b1;
				default: cnt_q <= cnt_q;
			endcase
			eops_q <= eops_q + {{AW{1'b0}}, push && eop_i}
				- {{AW{1'b0}}, pop && head[WW-2]};
		end
	end

	// Word appears one cycle after the read enable.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			val_o <= 1'b0;
			sop_o <= 1'b0;
			eop_o <= 1'b0;
			err_o <= 1'b0;
			mty_o <= '0;
			dat_o <= '0;
			adr_o <= '0;
		end
		else if (ce_i)
		begin
			val_o <= pop;
			if (pop)
			begin
				{sop_o, eop_o, err_o, mty_o, dat_o, adr_o} <= head;
			end
			else
			begin
				// Markers never outlive their word.
				sop_o <= 1'b0;
				eop_o <= 1'b0;
				err_o <= 1'b0;
			end
		end
	end
endmodule // lpp_pkt_fifo

// ---------------------------------------------------------------
// Device top: buffered receive and transmit packet ports.
// ---------------------------------------------------------------
module lpp_device #(
	parameter int XFER     = `LPP_XFER_SIZE,
	parameter int RX_LANES = `LPP_RX_LANES,
	parameter int TX_LANES = `LPP_TX_LANES,
	parameter int NFN      = `LPP_RX_FN,
	parameter int DEPTH    = `LPP_FIFO_DEPTH,
	parameter int THR      = `LPP_FILL_THR,
	localparam int RDW     = `LPP_BYTE_W * XFER * RX_LANES,
	localparam int TDW     = `LPP_BYTE_W * XFER * TX_LANES,
	localparam int RMW     = $clog2(RDW),
	localparam int TMW     = $clog2(TDW)
)(
	// Port clocks, reset, enable
	input  wire logic              RX_REG_CLK_I [NFN],
	input  wire logic              RX_HP_CLK_I  [NFN],
	input  wire logic              TX_REG_CLK_I,
	input  wire logic              TX_HP_CLK_I,
	input  wire logic              RST_B_I,
	input  wire logic              CE_I,
	// User-facing packet ports
	lpp_if.dev                     U,
	// Link side, receive regular
	input  wire logic              RX_REG_WR_I  [NFN],
	input  wire logic              RX_REG_SOP_I [NFN],
	input  wire logic              RX_REG_EOP_I [NFN],
	input  wire logic              RX_REG_ERR_I [NFN],
	input  wire logic [RMW-1:0]    RX_REG_MTY_I [NFN],
	input  wire logic [RDW-1:0]    RX_REG_DAT_I [NFN],
	input  wire lpp_pkg::lpp_adr_t RX_REG_ADR_I [NFN],
	output logic                   RX_REG_FULL_O [NFN],
	// Link side, receive high-priority
	input  wire logic              RX_HP_WR_I   [NFN],
	input  wire logic              RX_HP_SOP_I  [NFN],
	input  wire logic              RX_HP_EOP_I  [NFN],
	input  wire logic              RX_HP_ERR_I  [NFN],
	input  wire logic [RMW-1:0]    RX_HP_MTY_I  [NFN],
	input  wire logic [RDW-1:0]    RX_HP_DAT_I  [NFN],
	input  wire lpp_pkg::lpp_adr_t RX_HP_ADR_I  [NFN],
	output logic                   RX_HP_FULL_O [NFN],
	// Link side, transmit regular and high-priority
	input  wire logic              TX_REG_RD_I,
	output logic                   TX_REG_VAL_O,
	output logic                   TX_REG_SOP_O,
	output logic                   TX_REG_EOP_O,
	output logic                   TX_REG_ERR_O,
	output logic [TMW-1:0]         TX_REG_MTY_O,
	output logic [TDW-1:0]         TX_REG_DAT_O,
	output lpp_pkg::lpp_adr_t      TX_REG_ADR_O,
	input  wire logic              TX_HP_RD_I,
	output logic                   TX_HP_VAL_O,
	output logic                   TX_HP_SOP_O,
	output logic                   TX_HP_EOP_O,
	output logic                   TX_HP_ERR_O,
	output logic [TMW-1:0]         TX_HP_MTY_O,
	output logic [TDW-1:0]         TX_HP_DAT_O,
	output lpp_pkg::lpp_adr_t      TX_HP_ADR_O
);
	import lpp_pkg::*;

	logic tr_full;
	logic th_full;

	// This build always has the link layer with buffers, so the ports exist.
	// One regular and one high-priority receive buffer per function.
	for (genvar i = 0; i < NFN; i++)
	begin : g_rx
		lpp_pkt_fifo #(.DW(RDW), .MW(RMW), .DEPTH(DEPTH), .THR(THR))
		u_reg (
			.clk_i  (RX_REG_CLK_I[i]),
			.rst_b_i(RST_B_I),
			.ce_i   (CE_I),
			.wr_i   (RX_REG_WR_I[i]),
			.sop_i  (RX_REG_SOP_I[i]),
			.eop_i  (RX_REG_EOP_I[i]),
			.err_i  (RX_REG_ERR_I[i]),
			.mty_i  (RX_REG_MTY_I[i]),
			.dat_i  (RX_REG_DAT_I[i]),
			.adr_i  (RX_REG_ADR_I[i]),
			.full_o (RX_REG_FULL_O[i]),
			.dav_o  (U.rr_dav[i]),
			.rd_i   (U.rr_ena[i]),
			.val_o  (U.rr_val[i]),
			.sop_o  (U.rr_sop[i]),
			.eop_o  (U.rr_eop[i]),
			.err_o  (U.rr_err[i]),
			.mty_o  (U.rr_mty[i]),
			.dat_o  (U.rr_dat[i]),
			.adr_o  (U.rr_adr[i])
		);
		lpp_pkt_fifo #(.DW(RDW), .MW(RMW), .DEPTH(DEPTH), .THR(THR))
		u_hp (
			.clk_i  (RX_HP_CLK_I[i]),
			.rst_b_i(RST_B_I),
			.ce_i   (CE_I),
			.wr_i   (RX_HP_WR_I[i]),
			.sop_i  (RX_HP_SOP_I[i]),
			.eop_i  (RX_HP_EOP_I[i]),
			.err_i  (RX_HP_ERR_I[i]),
			.mty_i  (RX_HP_MTY_I[i]),
			.dat_i  (RX_HP_DAT_I[i]),
			.adr_i  (RX_HP_ADR_I[i]),
			.full_o (RX_HP_FULL_O[i]),
			.dav_o  (U.rh_dav[i]),
			.rd_i   (U.rh_ena[i]),
			.val_o  (U.rh_val[i]),
			.sop_o  (U.rh_sop[i]),
			.eop_o  (U.rh_eop[i]),
			.err_o  (U.rh_err[i]),
			.mty_o  (U.rh_mty[i]),
			.dat_o  (U.rh_dat[i]),
			.adr_o  (U.rh_adr[i])
		);
	end

	// Transmit buffers: the user fills, the link drains.
	lpp_pkt_fifo #(.DW(TDW), .MW(TMW), .DEPTH(DEPTH), .THR(THR)) u_tx_reg (
		.clk_i  (TX_REG_CLK_I),
		.rst_b_i(RST_B_I),
		.ce_i   (CE_I),
		.wr_i   (U.tr_ena),
		.sop_i  (U.tr_sop),
		.eop_i  (U.tr_eop),
		.err_i  (U.tr_err),
		.mty_i  (U.tr_mty),
		.dat_i  (U.tr_dat),
		.adr_i  (U.tr_adr),
		.full_o (tr_full),
		.dav_o  (),
		.rd_i   (TX_REG_RD_I),
		.val_o  (TX_REG_VAL_O),
		.sop_o  (TX_REG_SOP_O),
		.eop_o  (TX_REG_EOP_O),
		.err_o  (TX_REG_ERR_O),
		.mty_o  (TX_REG_MTY_O),
		.dat_o  (TX_REG_DAT_O),
		.adr_o  (TX_REG_ADR_O)
	);
	lpp_pkt_fifo #(.DW(TDW), .MW(TMW), .DEPTH(DEPTH), .THR(THR)) u_tx_hp (
		.clk_i  (TX_HP_CLK_I),
		.rst_b_i(RST_B_I),
		.ce_i   (CE_I),
		.wr_i   (U.th_ena),
		.sop_i  (U.th_sop),
		.eop_i  (U.th_eop),
		.err_i  (U.th_err),
		.mty_i  (U.th_mty),
		.dat_i  (U.th_dat),
		.adr_i  (U.th_adr),
		.full_o (th_full),
		.dav_o  (),
		.rd_i   (TX_HP_RD_I),
		.val_o  (TX_HP_VAL_O),
		.sop_o  (TX_HP_SOP_O),
		.eop_o  (TX_HP_EOP_O),
		.err_o  (TX_HP_ERR_O),
		.mty_o  (TX_HP_MTY_O),
		.dat_o  (TX_HP_DAT_O),
		.adr_o  (TX_HP_ADR_O)
	);

	assign U.tr_dav = !tr_full;
	assign U.th_dav = !th_full;
endmodule // lpp_device

`default_nettype wire

// File: core/lpp_if.sv
// Interface joining the link-layer packet ports to the user logic.
`timescale 1ns/1ns
`default_nettype none

interface lpp_if #(
	parameter int RDW = 16,
	parameter int TDW = 16,
	parameter int NFN = 1
);
	localparam int RMW = $clog2(RDW);
	localparam int TMW = $clog2(TDW);

	// Receive regular and receive high-priority, one copy per function.
	logic                 rr_ena [NFN];
	logic                 rr_dav [NFN];
	logic                 rr_val [NFN];
	logic                 rr_sop [NFN];
	logic                 rr_eop [NFN];
	logic                 rr_err [NFN];
	logic [RMW-1:0]       rr_mty [NFN];
	logic [RDW-1:0]       rr_dat [NFN];
	lpp_pkg::lpp_adr_t    rr_adr [NFN];
	logic                 rh_ena [NFN];
	logic                 rh_dav [NFN];
	logic                 rh_val [NFN];
	logic                 rh_sop [NFN];
	logic                 rh_eop [NFN];
	logic                 rh_err [NFN];
	logic [RMW-1:0]       rh_mty [NFN];
	logic [RDW-1:0]       rh_dat [NFN];
	lpp_pkg::lpp_adr_t    rh_adr [NFN];
	// Transmit regular and transmit high-priority.
	logic                 tr_ena;
	logic                 tr_dav;
	logic                 tr_sop;
	logic                 tr_eop;
	logic                 tr_err;
	logic [TMW-1:0]       tr_mty;
	logic [TDW-1:0]       tr_dat;
	lpp_pkg::lpp_adr_t    tr_adr;
	logic                 th_ena;
	logic                 th_dav;
	logic                 th_sop;
	logic                 th_eop;
	logic                 th_err;
	logic [TMW-1:0]       th_mty;
	logic [TDW-1:0]       th_dat;
	lpp_pkg::lpp_adr_t    th_adr;

	modport dev (
		input  rr_ena, rh_ena,
		output rr_dav, rr_val, rr_sop, rr_eop, rr_err, rr_mty, rr_dat, rr_adr,
		output rh_dav, rh_val, rh_sop, rh_eop, rh_err, rh_mty, rh_dat, rh_adr,
		input  tr_ena, tr_sop, tr_eop, tr_err, tr_mty, tr_dat, tr_adr,
		input  th_ena, th_sop, th_eop, th_err, th_mty, th_dat, th_adr,
		output tr_dav, th_dav
	);
	modport usr (
		output rr_ena, rh_ena,
		input  rr_dav, rr_val, rr_sop, rr_eop, rr_err, rr_mty, rr_dat, rr_adr,
		input  rh_dav, rh_val, rh_sop, rh_eop, rh_err, rh_mty, rh_dat, rh_adr,
		output tr_ena, tr_sop, tr_eop, tr_err, tr_mty, tr_dat, tr_adr,
		output th_ena, th_sop, th_eop, th_err, th_mty, th_dat, th_adr,
		input  tr_dav, th_dav
	);
endinterface // lpp_if

`default_nettype wire

// File: core/lpp_map.svh
// Constants of the packet port pair: widths, buffer sizing, defaults.
`ifndef LPP_MAP_SVH
`define LPP_MAP_SVH

`define LPP_BYTE_W     8
`define LPP_ADR_W      8
`define LPP_XFER_SIZE  2
`define LPP_RX_LANES   1
`define LPP_TX_LANES   1
`define LPP_RX_FN      1
`define LPP_FIFO_DEPTH 16
`define LPP_FILL_THR   8

`endif

// File: core/lpp_pkg.sv
// Types shared by both ends of the packet ports.
`include "lpp_map.svh"

package lpp_pkg;
	typedef logic [`LPP_ADR_W-1:0] lpp_adr_t;
endpackage

// File: core/lpp_user.sv
// User end of the packet ports: packet reader and packet writer.
`timescale 1ns/1ns
`default_nettype none
`include "lpp_map.svh"

// ---------------------------------------------------------------
// Receive reader: drains while allowed, folds errors per packet.
// ---------------------------------------------------------------
module lpp_user_rx #(
	parameter int DW = 16,
	parameter int MW = 4
)(
	// Clock, reset, enable
	input  wire logic              clk_i,
	input  wire logic              rst_b_i,
	input  wire logic              ce_i,
	// Port side
	output logic                   ena_o,
	input  wire logic              dav_i,
	input  wire logic              val_i,
	input  wire logic              sop_i,
	input  wire logic              eop_i,
	input  wire logic              err_i,
	input  wire logic [MW-1:0]     mty_i,
	input  wire logic [DW-1:0]     dat_i,
	input  wire lpp_pkg::lpp_adr_t adr_i,
	// User side
	input  wire logic              rd_en_i,
	output logic                   val_o,
	output logic                   sop_o,
	output logic                   eop_o,
	output logic                   err_o,
	output logic [MW-1:0]          mty_o,
	output logic [DW-1:0]          dat_o,
	output lpp_pkg::lpp_adr_t      adr_o
);
	import lpp_pkg::*;

	logic err_acc_q;

	// Reads only while the port signals enough data or a whole packet.
	assign ena_o = rd_en_i && dav_i && ce_i;

	// The error may pulse mid-packet, so it is held until the last word.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			err_acc_q <= 1'b0;
		end
		else if (ce_i && val_i)
		begin
			err_acc_q <= eop_i ? 1'b0 : (err_acc_q || err_i);
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			val_o <= 1'b0;
			sop_o <= 1'b0;
			eop_o <= 1'b0;
			err_o <= 1'b0;
			mty_o <= '0;
			dat_o <= '0;
			adr_o <= '0;
		end
		else if (ce_i)
		begin
			val_o <= val_i;
			if (val_i)
			begin
				sop_o <= sop_i;
				eop_o <= eop_i;
				err_o <= err_acc_q || err_i;
				mty_o <= mty_i;
				dat_o <= dat_i;
				if (sop_i)
				begin
					adr_o <= adr_i;
				end
			end
		end
	end
endmodule // lpp_user_rx

// ---------------------------------------------------------------
// Transmit writer: one word in flight, markers only with enable.
// ---------------------------------------------------------------
module lpp_user_tx #(
	parameter int DW = 16,
	parameter int MW = 4
)(
	// Clock, reset, enable
	input  wire logic              clk_i,
	input  wire logic              rst_b_i,
	input  wire logic              ce_i,
	// Port side
	output logic                   ena_o,
	input  wire logic              dav_i,
	output logic                   sop_o,
	output logic                   eop_o,
	output logic                   err_o,
	output logic [MW-1:0]          mty_o,
	output logic [DW-1:0]          dat_o,
	output lpp_pkg::lpp_adr_t      adr_o,
	// User side
	input  wire logic              valid_i,
	output logic                   ready_o,
	input  wire logic              sop_i,
	input  wire logic              eop_i,
	input  wire logic              err_i,
	input  wire logic [MW-1:0]     mty_i,
	input  wire logic [DW-1:0]     dat_i,
	input  wire lpp_pkg::lpp_adr_t adr_i
);
	import lpp_pkg::*;

	logic take;

	// Space is seen one cycle late, so no word is taken while one is
	// being written; this halves the rate but never overfills.
	assign ready_o = dav_i && !ena_o;
	assign take    = valid_i && ready_o;

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			ena_o <= 1'b0;
			sop_o <= 1'b0;
			eop_o <= 1'b0;
			err_o <= 1'b0;
			mty_o <= '0;
			dat_o <= '0;
			adr_o <= '0;
		end
		else if (ce_i)
		begin
			ena_o <= take;
			sop_o <= take && sop_i;
			eop_o <= take && eop_i;
			err_o <= take && err_i;
			mty_o <= take ? mty_i : '0;
			if (take)
			begin
				dat_o <= dat_i;
				adr_o <= adr_i;
			end
		end
	end
endmodule // lpp_user_tx

// ---------------------------------------------------------------
// User top: readers per function, writers per priority.
// ---------------------------------------------------------------
module lpp_user #(
	parameter int XFER     = `LPP_XFER_SIZE,
	parameter int RX_LANES = `LPP_RX_LANES,
	parameter int TX_LANES = `LPP_TX_LANES,
	parameter int NFN      = `LPP_RX_FN,
	localparam int RDW     = `LPP_BYTE_W * XFER * RX_LANES,
	localparam int TDW     = `LPP_BYTE_W * XFER * TX_LANES,
	localparam int RMW     = $clog2(RDW),
	localparam int TMW     = $clog2(TDW)
)(
	// Port clocks, reset, enable
	input  wire logic              RX_REG_CLK_I [NFN],
	input  wire logic              RX_HP_CLK_I  [NFN],
	input  wire logic              TX_REG_CLK_I,
	input  wire logic              TX_HP_CLK_I,
	input  wire logic              RST_B_I,
	input  wire logic              CE_I,
	// Packet ports
	lpp_if.usr                     U,
	// Receive, index 0 regular and 1 high-priority
	input  wire logic              RX_RD_EN_I [2][NFN],
	output logic                   RX_VAL_O   [2][NFN],
	output logic                   RX_SOP_O   [2][NFN],
	output logic                   RX_EOP_O   [2][NFN],
	output logic                   RX_ERR_O   [2][NFN],
	output logic [RMW-1:0]         RX_MTY_O   [2][NFN],
	output logic [RDW-1:0]         RX_DAT_O   [2][NFN],
	output lpp_pkg::lpp_adr_t      RX_ADR_O   [2][NFN],
	// Transmit, index 0 regular and 1 high-priority
	input  wire logic              TX_VALID_I [2],
	output logic                   TX_READY_O [2],
	input  wire logic              TX_SOP_I   [2],
	input  wire logic              TX_EOP_I   [2],
	input  wire logic              TX_ERR_I   [2],
	input  wire logic [TMW-1:0]    TX_MTY_I   [2],
	input  wire logic [TDW-1:0]    TX_DAT_I   [2],
	input  wire lpp_pkg::lpp_adr_t TX_ADR_I   [2]
);
	import lpp_pkg::*;

	for (genvar i = 0; i < NFN; i++)
	begin : g_rx
		lpp_user_rx #(.DW(RDW), .MW(RMW)) u_reg (
			.clk_i(RX_REG_CLK_I[i]), .rst_b_i(RST_B_I), .ce_i(CE_I),
			.ena_o(U.rr_ena[i]), .dav_i(U.rr_dav[i]), .val_i(U.rr_val[i]),
			.sop_i(U.rr_sop[i]), .eop_i(U.rr_eop[i]), .err_i(U.rr_err[i]),
			.mty_i(U.rr_mty[i]), .dat_i(U.rr_dat[i]), .adr_i(U.rr_adr[i]),
			.rd_en_i(RX_RD_EN_I[0][i]), .val_o(RX_VAL_O[0][i]),
			.sop_o(RX_SOP_O[0][i]), .eop_o(RX_EOP_O[0][i]),
			.err_o(RX_ERR_O[0][i]), .mty_o(RX_MTY_O[0][i]),
			.dat_o(RX_DAT_O[0][i]), .adr_o(RX_ADR_O[0][i])
		);
		lpp_user_rx #(.DW(RDW), .MW(RMW)) u_hp (
			.clk_i(RX_HP_CLK_I[i]), .rst_b_i(RST_B_I), .ce_i(CE_I),
			.ena_o(U.rh_ena[i]), .dav_i(U.rh_dav[i]), .val_i(U.rh_val[i]),
			.sop_i(U.rh_sop[i]), .eop_i(U.rh_eop[i]), .err_i(U.rh_err[i]),
			.mty_i(U.rh_mty[i]), .dat_i(U.rh_dat[i]), .adr_i(U.rh_adr[i]),
			.rd_en_i(RX_RD_EN_I[1][i]), .val_o(RX_VAL_O[1][i]),
			.sop_o(RX_SOP_O[1][i]), .eop_o(RX_EOP_O[1][i]),
			.err_o(RX_ERR_O[1][i]), .mty_o(RX_MTY_O[1][i]),
			.dat_o(RX_DAT_O[1][i]), .adr_o(RX_ADR_O[1][i])
		);
	end

	lpp_user_tx #(.DW(TDW), .MW(TMW)) u_tx_reg (
		.clk_i(TX_REG_CLK_I), .rst_b_i(RST_B_I), .ce_i(CE_I),
		.ena_o(U.tr_ena), .dav_i(U.tr_dav), .sop_o(U.tr_sop),
		.eop_o(U.tr_eop), .err_o(U.tr_err), .mty_o(U.tr_mty),
		.dat_o(U.tr_dat), .adr_o(U.tr_adr),
		.valid_i(TX_VALID_I[0]), .ready_o(TX_READY_O[0]),
		.sop_i(TX_SOP_I[0]), .eop_i(TX_EOP_I[0]), .err_i(TX_ERR_I[0]),
		.mty_i(TX_MTY_I[0]), .dat_i(TX_DAT_I[0]), .adr_i(TX_ADR_I[0])
	);
	lpp_user_tx #(.DW(TDW), .MW(TMW)) u_tx_hp (
		.clk_i(TX_HP_CLK_I), .rst_b_i(RST_B_I), .ce_i(CE_I),
		.ena_o(U.th_ena), .dav_i(U.th_dav), .sop_o(U.th_sop),
		.eop_o(U.th_eop), .err_o(U.th_err), .mty_o(U.th_mty),
		.dat_o(U.th_dat), .adr_o(U.th_adr),
		.valid_i(TX_VALID_I[1]), .ready_o(TX_READY_O[1]),
		.sop_i(TX_SOP_I[1]), .eop_i(TX_EOP_I[1]), .err_i(TX_ERR_I[1]),
		.mty_i(TX_MTY_I[1]), .dat_i(TX_DAT_I[1]), .adr_i(TX_ADR_I[1])
	);
endmodule // lpp_user

`default_nettype wire

// File: tb/lpp_pair_monitor.sv
// Checker of the packet port signals between the device and user ends.
`timescale 1ns/1ns
`default_nettype none

module lpp_pair_monitor (
	// Clock and reset
	input wire logic TX_REG_CLK_I,
	input wire logic RST_B_I,
	// Receive side
	input wire logic rr_ena,
	input wire logic rr_dav,
	input wire logic rr_val,
	input wire logic rr_sop,
	input wire logic rr_eop,
	input wire logic rr_err,
	input wire logic rh_ena,
	input wire logic rh_val,
	// Transmit side
	input wire logic tr_ena,
	input wire logic tr_dav,
	input wire logic tr_sop,
	input wire logic tr_eop,
	input wire logic tr_err,
	input wire logic th_ena,
	input wire logic th_sop
);
	// All port clocks share one source in this bench.
	default clocking @(posedge TX_REG_CLK_I); endclocking
	default disable iff (!RST_B_I);

	chk_rx_val_ena: assert property (rr_val |-> $past(rr_ena))
		else $error("Receive valid without a prior enable.");
	chk_rx_read_ans: assert property (rr_ena && rr_dav |=> rr_val)
		else $error("Receive read gave no word.");
	chk_rx_mark_val: assert property ((rr_sop || rr_eop || rr_err) |-> rr_val)
		else $error("Receive marker outside a valid word.");
	chk_rx_dav_fall: assert property ($fell(rr_dav) |-> rr_val || $past(rr_val))
		else $error("Receive available dropped without a read.");
	chk_tx_full_cause: assert property ($fell(tr_dav) |-> $past(tr_ena))
		else $error("Transmit space dropped without a write.");
	chk_tx_mark_ena: assert property ((tr_sop || tr_eop || tr_err) |-> tr_ena)
		else $error("Transmit marker without write enable.");
	chk_tx_write_gap: assert property (tr_ena |=> !tr_ena)
		else $error("Transmit writes closer than the writer allows.");
	chk_hp_val_ena: assert property (rh_val |-> $past(rh_ena))
		else $error("Priority receive valid without enable.");
	chk_hp_mark_ena: assert property (th_sop |-> th_ena)
		else $error("Priority transmit start without enable.");
endmodule // lpp_pair_monitor

`default_nettype wire

// File: tb/testbench.sv
// Bench joining the device and user ends of the packet ports.
`timescale 1ns/1ns
`default_nettype none
`include "lpp_map.svh"

module testbench;
	import lpp_pkg::*;
	localparam int DW = `LPP_BYTE_W * `LPP_XFER_SIZE * `LPP_RX_LANES;
	localparam int MW = $clog2(DW);
	logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, ck [1];
	logic lw [2][1], ls [2][1], le [2][1], lr [2][1], lf [2][1], ren [2][1];
	logic uv [2][1], us [2][1], ue [2][1], ur [2][1];
	logic [MW-1:0] lm [2][1], um [2][1], tm [2], xm [2];
	logic [DW-1:0] ld [2][1], ud [2][1], td [2], xd [2];
	lpp_adr_t la [2][1], ua [2][1], ta [2], xa [2];
	logic tv [2], trdy [2], ts [2], te [2], tr [2], trd [2];
	logic xv [2], xs [2], xe [2], xr [2];
	int n_checks = 0, n_mismatch = 0;
	assign ck[0] = clk;
	always #5 clk = ~clk;
	lpp_if #(.RDW(DW), .TDW(DW), .NFN(1)) bus ();
	lpp_device u_lpp_device (.RX_REG_CLK_I(ck), .RX_HP_CLK_I(ck),
		.TX_REG_CLK_I(clk), .TX_HP_CLK_I(clk), .RST_B_I(rst_b), .CE_I(ce),
		.U(bus), .RX_REG_WR_I(lw[0]), .RX_REG_SOP_I(ls[0]),
		.RX_REG_EOP_I(le[0]), .RX_REG_ERR_I(lr[0]), .RX_REG_MTY_I(lm[0]),
		.RX_REG_DAT_I(ld[0]), .RX_REG_ADR_I(la[0]), .RX_REG_FULL_O(lf[0]),
		.RX_HP_WR_I(lw[1]), .RX_HP_SOP_I(ls[1]), .RX_HP_EOP_I(le[1]),
		.RX_HP_ERR_I(lr[1]), .RX_HP_MTY_I(lm[1]), .RX_HP_DAT_I(ld[1]),
		.RX_HP_ADR_I(la[1]), .RX_HP_FULL_O(lf[1]), .TX_REG_RD_I(trd[0]),
		.TX_REG_VAL_O(xv[0]), .TX_REG_SOP_O(xs[0]), .TX_REG_EOP_O(xe[0]),
		.TX_REG_ERR_O(xr[0]), .TX_REG_MTY_O(xm[0]), .TX_REG_DAT_O(xd[0]),
		.TX_REG_ADR_O(xa[0]), .TX_HP_RD_I(trd[1]), .TX_HP_VAL_O(xv[1]),
		.TX_HP_SOP_O(xs[1]), .TX_HP_EOP_O(xe[1]), .TX_HP_ERR_O(xr[1]),
		.TX_HP_MTY_O(xm[1]), .TX_HP_DAT_O(xd[1]), .TX_HP_ADR_O(xa[1]));
	lpp_user u_lpp_user (.RX_REG_CLK_I(ck), .RX_HP_CLK_I(ck),
		.TX_REG_CLK_I(clk), .TX_HP_CLK_I(clk), .RST_B_I(rst_b), .CE_I(ce),
		.U(bus), .RX_RD_EN_I(ren), .RX_VAL_O(uv), .RX_SOP_O(us),
		.RX_EOP_O(ue), .RX_ERR_O(ur), .RX_MTY_O(um), .RX_DAT_O(ud),
		.RX_ADR_O(ua), .TX_VALID_I(tv), .TX_READY_O(trdy), .TX_SOP_I(ts),
		.TX_EOP_I(te), .TX_ERR_I(tr), .TX_MTY_I(tm), .TX_DAT_I(td),
		.TX_ADR_I(ta));
	lpp_pair_monitor u_lpp_pair_monitor (.TX_REG_CLK_I(clk), .RST_B_I(rst_b),
		.rr_ena(bus.rr_ena[0]), .rr_dav(bus.rr_dav[0]), .rr_val(bus.rr_val[0]),
		.rr_sop(bus.rr_sop[0]), .rr_eop(bus.rr_eop[0]), .rr_err(bus.rr_err[0]),
		.rh_ena(bus.rh_ena[0]), .rh_val(bus.rh_val[0]), .tr_ena(bus.tr_ena),
		.tr_dav(bus.tr_dav), .tr_sop(bus.tr_sop), .tr_eop(bus.tr_eop),
		.tr_err(bus.tr_err), .th_ena(bus.th_ena), .th_sop(bus.th_sop));

	task test_done();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task cmp(input logic [15:0] g, input logic [15:0] x);
		n_checks++;
		if (g !== x)
		begin
			n_mismatch++;
			$display("ERROR %0t: got %h expected %h", $time, g, x);
		end
	endtask

	task hang();
		n_mismatch++;
		test_done();
	endtask

	function automatic logic rdav(input int p);
		return p ? bus.rh_dav[0] : bus.rr_dav[0];
	endfunction

	// Ten-word packet: start with ID, error on word 3, end with one empty byte.
	task automatic rx_pkt(input int p);
		int j;
		for (int i = 0; i <= 10; i++)
		begin
			@(posedge clk);
			lw[p][0] <= (i < 10);
			ls[p][0] <= (i == 0);
			le[p][0] <= (i == 9);
			lr[p][0] <= (i == 3);
			lm[p][0] <= (i == 9) ? 4'h1 : 4'h0;
			ld[p][0] <= 16'ha000 + 16'(p * 256 + i);
			la[p][0] <= 8'h5a + 8'(p);
			@(negedge clk);
			cmp({rdav(p), lf[p][0]}, {i > 8, 1'b0});
		end
		@(posedge clk);
		ren[p][0] <= 1'b1;
		j = 0;
		for (int k = 0; k < 60 && j < 10; k++)
		begin
			@(negedge clk);
			if (j < 8)
				cmp(16'(rdav(p)), 16'h0001);
			if (uv[p][0] === 1'b1)
			begin
				cmp({us[p][0], ue[p][0], ur[p][0], 1'b0, um[p][0], ua[p][0]},
					{j == 0, j == 9, j >= 3, 1'b0, (j == 9) ? 4'h1 : 4'h0,
					8'h5a + 8'(p)});
				cmp(ud[p][0], 16'ha000 + 16'(p * 256 + j));
				j++;
			end
		end
		if (j < 10)
			hang();
		@(posedge clk);
		ren[p][0] <= 1'b0;
		@(negedge clk);
		cmp(16'(rdav(p)), 16'h0000);
	endtask

	task automatic tword(input int p, input int i);
		ts[p] <= (i == 0);
		te[p] <= (i == 15);
		tr[p] <= (i == 15);
		tm[p] <= (i == 15) ? 4'h2 : 4'h0;
		td[p] <= 16'hc000 + 16'(p * 256 + i);
		ta[p] <= 8'h3c + 8'(p);
	endtask

	// Fill the transmit buffer to full, then drain it from the link side.
	task automatic tx_pkt(input int p);
		int k;
		@(posedge clk);
		tv[p] <= 1'b1;
		tword(p, 0);
		for (int i = 0; i < 16; i++)
		begin
			k = 0;
			do
			begin
				@(negedge clk);
				k++;
			end while (trdy[p] !== 1'b1 && k < 50);
			if (k >= 50)
				hang();
			@(posedge clk);
			tv[p] <= (i < 15);
			tword(p, i + 1);
		end
		@(posedge clk);
		@(negedge clk);
		cmp({p ? bus.th_dav : bus.tr_dav, trdy[p]}, 16'h0000);
		// Enable low must freeze the full buffer despite a pending read.
		@(posedge clk);
		ce <= 1'b0;
		trd[p] <= 1'b1;
		repeat (3) @(posedge clk);
		@(negedge clk);
		cmp({xv[p], p ? bus.th_dav : bus.tr_dav}, 16'h0000);
		@(posedge clk);
		ce <= 1'b1;
		trd[p] <= 1'b0;
		for (int i = 0; i <= 16; i++)
		begin
			@(posedge clk);
			trd[p] <= (i < 16);
			@(negedge clk);
			if (i > 0)
			begin
				cmp({xv[p], xs[p], xe[p], xr[p], xm[p], xa[p]}, {1'b1, i == 1,
					i == 16, i == 16, (i == 16) ? 4'h2 : 4'h0,
					8'h3c + 8'(p)});
				cmp(xd[p], 16'hc000 + 16'(p * 256 + i - 1));
			end
		end
		cmp(16'(p ? bus.th_dav : bus.tr_dav), 16'h0001);
	endtask

	initial
	begin
		lw = '{default: '0};
		ls = '{default: '0};
		le = '{default: '0};
		lr = '{default: '0};
		lm = '{default: '0};
		ld = '{default: '0};
		la = '{default: '0};
		ren = '{default: '0};
		tv = '{default: '0};
		ts = '{default: '0};
		te = '{default: '0};
		tr = '{default: '0};
		tm = '{default: '0};
		td = '{default: '0};
		ta = '{default: '0};
		trd = '{default: '0};
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		for (int p = 0; p < 2; p++)
		begin
			rx_pkt(p);
			tx_pkt(p);
		end
		test_done();
	end
endmodule // testbench

`default_nettype wire
